//--- design/adc_input_select_regs.sv
// Converter input select and scan mask registers on a Wishbone slave
// Operation
// - Sample B negative select, bits 15-13
// - Sample B positive select, bits 12-8
// - High scan word: bits 14-10, 1-0
// - Low scan bits include channel when set
// - Unimplemented scan bits always read zero
`timescale 1ns/10ps
`default_nettype none
`include "adcis_cfg.svh"
module adc_input_select_regs (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output adcis_pkg::adcis_mux_t muxSel,
	output logic [15:0] scanIncludeLow,
	output logic [15:0] scanIncludeHigh
);
	logic [15:0] sampleInputSelect;
	logic [15:0] scanSelectLow;
	logic [15:0] scanSelectHigh;
	adcis_pkg::adcis_state_t state;
	adcis_pkg::adcis_mux_t next_muxSel;
	adcis_pkg::adcis_neg_t negBSel;
	adcis_pkg::adcis_pos_t posBSel;
	adcis_pkg::adcis_neg_t negASel;
	adcis_pkg::adcis_pos_t posASel;
	logic request;
	logic mapped;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] sel, input logic [15:0] mask);
		logic [15:0] merged;
		merged = old;
		if (sel[0]) begin
			merged[7:0] = data[7:0];
		end
		if (sel[1]) begin
			merged[15:8] = data[15:8];
		end
		return merged & mask;
	endfunction : merge16

	function automatic logic isMapped(input logic [3:0] adr);
		return adr == `ADCIS_OFS_SAMPLE || adr == `ADCIS_OFS_SCAN_LOW ||
			adr == `ADCIS_OFS_SCAN_HIGH;
	endfunction : isMapped

	assign request = wb_cyc_i && wb_stb_i && state == adcis_pkg::ADCIS_IDLE;
	assign mapped = isMapped(wb_adr_i);

	// One registered answer, the cycle after the request; a new request is taken in the cycle after the answer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= adcis_pkg::ADCIS_IDLE;
		end else begin
			case (state)
				adcis_pkg::ADCIS_IDLE: begin
					if (request) begin
						state <= adcis_pkg::ADCIS_ACK;
					end
				end
				adcis_pkg::ADCIS_ACK: begin
					state <= adcis_pkg::ADCIS_IDLE;
				end
				default: begin
					state <= adcis_pkg::ADCIS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= request && mapped;
			wb_err_o <= request && !mapped;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sampleInputSelect <= `ADCIS_RST_SAMPLE;
		end else if (request && wb_we_i && wb_adr_i == `ADCIS_OFS_SAMPLE) begin
			sampleInputSelect <= merge16(sampleInputSelect, wb_dat_i, wb_sel_i,
				`ADCIS_MASK_SAMPLE);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scanSelectLow <= `ADCIS_RST_SCAN_LOW;
		end else if (request && wb_we_i && wb_adr_i == `ADCIS_OFS_SCAN_LOW) begin
			scanSelectLow <= merge16(scanSelectLow, wb_dat_i, wb_sel_i,
				`ADCIS_MASK_SCAN_LOW);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scanSelectHigh <= `ADCIS_RST_SCAN_HIGH;
		end else if (request && wb_we_i && wb_adr_i == `ADCIS_OFS_SCAN_HIGH) begin
			scanSelectHigh <= merge16(scanSelectHigh, wb_dat_i, wb_sel_i,
				`ADCIS_MASK_SCAN_HIGH);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (request && !wb_we_i) begin
			case (wb_adr_i)
				`ADCIS_OFS_SAMPLE: wb_dat_o <= {16'h0000, sampleInputSelect};
				`ADCIS_OFS_SCAN_LOW: wb_dat_o <= {16'h0000, scanSelectLow};
				`ADCIS_OFS_SCAN_HIGH: wb_dat_o <= {16'h0000, scanSelectHigh};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	adcis_neg_decode u_neg_b (
		.code(sampleInputSelect[`ADCIS_B_NEG_HI:`ADCIS_B_NEG_LO]),
		.sel(negBSel)
	);
	adcis_pos_decode u_pos_b (
		.code(sampleInputSelect[`ADCIS_B_POS_HI:`ADCIS_B_POS_LO]),
		.sel(posBSel)
	);
	adcis_neg_decode u_neg_a (
		.code(sampleInputSelect[`ADCIS_A_NEG_HI:`ADCIS_A_NEG_LO]),
		.sel(negASel)
	);
	adcis_pos_decode u_pos_a (
		.code(sampleInputSelect[`ADCIS_A_POS_HI:`ADCIS_A_POS_LO]),
		.sel(posASel)
	);

	assign next_muxSel = '{negB: negBSel, posB: posBSel, negA: negASel, posA: posASel};

	// Registered mux drive, one cycle behind the select register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			muxSel <= '0;
			scanIncludeLow <= 16'h0000;
			scanIncludeHigh <= 16'h0000;
		end else begin
			muxSel <= next_muxSel;
			scanIncludeLow <= scanSelectLow;
			scanIncludeHigh <= scanSelectHigh;
		end
	end

	// Decode of the registered mux drive
	a_neg_b_ground: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst) |-> muxSel.negB.groundSel == ($past(sampleInputSelect[15:13]) == 3'h0))
		else $error("sample B negative ground decode wrong");

	a_neg_b_index: assert property (@(posedge clk) disable iff (!nrst)
		sampleInputSelect[15:13] != 3'h0 |=> muxSel.negB.analogIndex ==
		3'($past(sampleInputSelect[15:13]) - 3'h1))
		else $error("sample B negative index wrong");

	a_neg_b_zero: assert property (@(posedge clk) disable iff (!nrst)
		muxSel.negB.groundSel |-> muxSel.negB.analogIndex == 3'h0)
		else $error("sample B ground with nonzero index");

	a_pos_b_map: assert property (@(posedge clk) disable iff (!nrst)
		(sampleInputSelect[12:8] >= 5'h01 && sampleInputSelect[12:8] <= 5'h0F)
		|=> muxSel.posB.validInput && muxSel.posB.analogIndex == $past(sampleInputSelect[11:8]))
		else $error("sample B positive decode wrong");

	a_pos_b_reject: assert property (@(posedge clk) disable iff (!nrst)
		(sampleInputSelect[12:8] == 5'h00 || sampleInputSelect[12:8] > 5'h0F)
		|=> !muxSel.posB.validInput && muxSel.posB.analogIndex == 4'h0)
		else $error("sample B positive reject wrong");

	a_neg_a_ground: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst) |-> muxSel.negA.groundSel == ($past(sampleInputSelect[7:5]) == 3'h0))
		else $error("sample A negative ground decode wrong");

	a_neg_a_index: assert property (@(posedge clk) disable iff (!nrst)
		sampleInputSelect[7:5] != 3'h0 |=> muxSel.negA.analogIndex ==
		3'($past(sampleInputSelect[7:5]) - 3'h1))
		else $error("sample A negative index wrong");

	a_neg_a_zero: assert property (@(posedge clk) disable iff (!nrst)
		muxSel.negA.groundSel |-> muxSel.negA.analogIndex == 3'h0)
		else $error("sample A ground with nonzero index");

	a_neg_a_same: assert property (@(posedge clk) disable iff (!nrst)
		sampleInputSelect[7:5] == sampleInputSelect[15:13] && $stable(sampleInputSelect)
		|=> muxSel.negA == muxSel.negB)
		else $error("sample A negative decode differs");

	a_pos_a_map: assert property (@(posedge clk) disable iff (!nrst)
		(sampleInputSelect[4:0] >= 5'h01 && sampleInputSelect[4:0] <= 5'h0F)
		|=> muxSel.posA.validInput && muxSel.posA.analogIndex == $past(sampleInputSelect[3:0]))
		else $error("sample A positive decode wrong");

	a_pos_a_reject: assert property (@(posedge clk) disable iff (!nrst)
		(sampleInputSelect[4:0] == 5'h00 || sampleInputSelect[4:0] > 5'h0F)
		|=> !muxSel.posA.validInput && muxSel.posA.analogIndex == 4'h0)
		else $error("sample A positive reject wrong");

	a_pos_a_same: assert property (@(posedge clk) disable iff (!nrst)
		sampleInputSelect[4:0] == sampleInputSelect[12:8] && $stable(sampleInputSelect)
		|=> muxSel.posA == muxSel.posB)
		else $error("sample A positive decode differs");

	// Register bus checks
	a_high_write: assert property (@(posedge clk) disable iff (!nrst)
		request && wb_we_i && wb_adr_i == 4'h8 && wb_sel_i[1:0] == 2'b11
		|=> scanSelectHigh == ($past(wb_dat_i[15:0]) & 16'h7C03))
		else $error("high scan word write wrong");

	a_low_write: assert property (@(posedge clk) disable iff (!nrst)
		request && wb_we_i && wb_adr_i == 4'h4 && wb_sel_i[1:0] == 2'b11
		|=> ##1 scanIncludeLow == $past(wb_dat_i[15:0], 2))
		else $error("low scan mask not driven");

	a_lane_low: assert property (@(posedge clk) disable iff (!nrst)
		request && wb_we_i && wb_adr_i == `ADCIS_OFS_SAMPLE && wb_sel_i[1:0] == 2'b10
		|=> sampleInputSelect[7:0] == $past(sampleInputSelect[7:0]))
		else $error("sample low byte changed by high lane write");

	a_lane_high: assert property (@(posedge clk) disable iff (!nrst)
		request && wb_we_i && wb_adr_i == `ADCIS_OFS_SAMPLE && wb_sel_i[1:0] == 2'b01
		|=> sampleInputSelect[15:8] == $past(sampleInputSelect[15:8]))
		else $error("sample high byte changed by low lane write");

	a_sample_read: assert property (@(posedge clk) disable iff (!nrst)
		wb_ack_o && $past(wb_adr_i) == `ADCIS_OFS_SAMPLE && !$past(wb_we_i)
		|-> wb_dat_o == {16'h0000, $past(sampleInputSelect)})
		else $error("sample select read data wrong");

	a_low_read: assert property (@(posedge clk) disable iff (!nrst)
		wb_ack_o && $past(wb_adr_i) == `ADCIS_OFS_SCAN_LOW && !$past(wb_we_i)
		|-> wb_dat_o == {16'h0000, $past(scanSelectLow)})
		else $error("low scan word read data wrong");

	a_high_read: assert property (@(posedge clk) disable iff (!nrst)
		wb_ack_o && $past(wb_adr_i) == `ADCIS_OFS_SCAN_HIGH && !$past(wb_we_i)
		|-> wb_dat_o == {16'h0000, $past(scanSelectHigh)})
		else $error("high scan word read data wrong");

	a_unimpl_zero: assert property (@(posedge clk) disable iff (!nrst)
		wb_ack_o && $past(wb_adr_i) == 4'h8 && !$past(wb_we_i) |->
		(wb_dat_o[15] == 1'b0 && wb_dat_o[9:2] == 8'h00))
		else $error("unimplemented scan bit read nonzero");

	a_high_unused: assert property (@(posedge clk) disable iff (!nrst)
		(scanSelectHigh & ~`ADCIS_MASK_SCAN_HIGH) == 16'h0000)
		else $error("unimplemented high scan bit set");

	a_out_unused: assert property (@(posedge clk) disable iff (!nrst)
		(scanIncludeHigh & ~`ADCIS_MASK_SCAN_HIGH) == 16'h0000)
		else $error("unimplemented scan channel driven");

	a_err_unmapped: assert property (@(posedge clk) disable iff (!nrst)
		request && !mapped |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");

	a_ack_once: assert property (@(posedge clk) disable iff (!nrst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	// Reset, follow and hold checks
	a_reset_regs: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> sampleInputSelect == 16'h0000 && scanSelectLow == 16'h0000 &&
		scanSelectHigh == 16'h0000)
		else $error("registers not cleared by reset");

	a_reset_outs: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> muxSel == '0 && scanIncludeLow == 16'h0000 &&
		scanIncludeHigh == 16'h0000)
		else $error("mux drive not cleared by reset");

	a_low_follow: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst) |-> scanIncludeLow == $past(scanSelectLow))
		else $error("low scan drive does not follow register");

	a_high_follow: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst) |-> scanIncludeHigh == $past(scanSelectHigh))
		else $error("high scan drive does not follow register");

	a_sample_hold: assert property (@(posedge clk) disable iff (!nrst)
		!(request && wb_we_i && wb_adr_i == `ADCIS_OFS_SAMPLE) |=> $stable(sampleInputSelect))
		else $error("sample select changed without write");

	a_low_hold: assert property (@(posedge clk) disable iff (!nrst)
		!(request && wb_we_i && wb_adr_i == `ADCIS_OFS_SCAN_LOW) |=> $stable(scanSelectLow))
		else $error("low scan word changed without write");

	a_high_hold: assert property (@(posedge clk) disable iff (!nrst)
		!(request && wb_we_i && wb_adr_i == `ADCIS_OFS_SCAN_HIGH) |=> $stable(scanSelectHigh))
		else $error("high scan word changed without write");

endmodule : adc_input_select_regs
`default_nettype wire

//--- design/adcis_cfg.svh
// Register offsets, field positions, reset values and masks for the input select block
`ifndef ADCIS_CFG_SVH
`define ADCIS_CFG_SVH

`define ADCIS_OFS_SAMPLE 4'h0
`define ADCIS_OFS_SCAN_LOW 4'h4
`define ADCIS_OFS_SCAN_HIGH 4'h8

`define ADCIS_RST_SAMPLE 16'h0000
`define ADCIS_RST_SCAN_LOW 16'h0000
`define ADCIS_RST_SCAN_HIGH 16'h0000

`define ADCIS_B_NEG_HI 15
`define ADCIS_B_NEG_LO 13
`define ADCIS_B_POS_HI 12
`define ADCIS_B_POS_LO 8
`define ADCIS_A_NEG_HI 7
`define ADCIS_A_NEG_LO 5
`define ADCIS_A_POS_HI 4
`define ADCIS_A_POS_LO 0

`define ADCIS_MASK_SAMPLE 16'hFFFF
`define ADCIS_MASK_SCAN_LOW 16'hFFFF
`define ADCIS_MASK_SCAN_HIGH 16'h7C03

`define ADCIS_NEG_GROUND 3'h0
`define ADCIS_POS_AN_MAX 5'h0F
`define ADCIS_POS_AN_MIN 5'h01

`endif

//--- design/adcis_neg_decode.sv
// Negative input selector decode
`timescale 1ns/10ps
`default_nettype none
`include "adcis_cfg.svh"
module adcis_neg_decode (
	input wire logic [2:0] code,
	output adcis_pkg::adcis_neg_t sel
);
	always_comb begin
		sel.groundSel = (code == `ADCIS_NEG_GROUND);
		sel.analogIndex = (code == `ADCIS_NEG_GROUND) ? 3'h0 : 3'(code - 3'h1);
	end
endmodule : adcis_neg_decode
`default_nettype wire

//--- design/adcis_pkg.sv
// Types shared by the input select block
`default_nettype none
package adcis_pkg;

	typedef struct packed {
		logic groundSel;
		logic [2:0] analogIndex;
	} adcis_neg_t;

	typedef struct packed {
		logic validInput;
		logic [3:0] analogIndex;
	} adcis_pos_t;

	typedef struct packed {
		adcis_neg_t negB;
		adcis_pos_t posB;
		adcis_neg_t negA;
		adcis_pos_t posA;
	} adcis_mux_t;

	typedef enum logic [1:0] {
		ADCIS_IDLE = 2'b00,
		ADCIS_ACK = 2'b01
	} adcis_state_t;

endpackage : adcis_pkg
`default_nettype wire

//--- design/adcis_pos_decode.sv
// Positive input selector decode
`timescale 1ns/10ps
`default_nettype none
`include "adcis_cfg.svh"
module adcis_pos_decode (
	input wire logic [4:0] code,
	output adcis_pkg::adcis_pos_t sel
);
	always_comb begin
		sel.validInput = (code >= `ADCIS_POS_AN_MIN) && (code <= `ADCIS_POS_AN_MAX);
		sel.analogIndex = sel.validInput ? code[3:0] : 4'h0;
	end
endmodule : adcis_pos_decode
`default_nettype wire

//--- dv/adcis_mux_model.sv
// Scan sequencer model counting the channels it would visit
`timescale 1ns/10ps
`default_nettype none
module adcis_mux_model (
	input wire logic [15:0] scanIncludeLow,
	input wire logic [15:0] scanIncludeHigh,
	output logic [5:0] scanCount
);
	// Set bits are visited, clear bits skipped
	assign scanCount = 6'($countones({scanIncludeHigh, scanIncludeLow}));
endmodule : adcis_mux_model
`default_nettype wire

//--- dv/tb.sv
// Testbench for the input select registers
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk, nrst, cyc, stb, we, ack, err, er;
	logic [3:0] adr, sel;
	logic [31:0] datI, datO, rd;
	adcis_pkg::adcis_mux_t muxSel;
	logic [15:0] scanLow, scanHigh, v;
	logic [5:0] scanCount;
	int err_count = 0;
	int cmp_count = 0;
	int seed = 16;
	adc_input_select_regs u_adc_input_select_regs (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
		.wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err), .muxSel(muxSel),
		.scanIncludeLow(scanLow), .scanIncludeHigh(scanHigh));
	adcis_mux_model u_adcis_mux_model (.scanIncludeLow(scanLow),
		.scanIncludeHigh(scanHigh), .scanCount(scanCount));
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	function automatic logic [3:0] negExp(input logic [2:0] c);
		return (c == 3'h0) ? 4'h8 : {1'b0, c - 3'h1};
	endfunction : negExp
	function automatic logic [4:0] posExp(input logic [4:0] c);
		return (c >= 5'h01 && c <= 5'h0f) ? {1'b1, c[3:0]} : 5'h00;
	endfunction : posExp
	function automatic logic [15:0] legalSel(input logic [15:0] c);
		logic [15:0] r;
		r = c;
		if (c[12:8] inside {[5'h12:5'h18], 5'h1f}) r[12] = 1'b0;
		if (c[4:0] inside {[5'h12:5'h18], 5'h1f}) r[4] = 1'b0;
		return r;
	endfunction : legalSel
	task automatic give_verdict;
		$display("Compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= d;
		sel <= s;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1 && err !== 1'b1);
		rd = datO;
		er = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	initial begin
		#100_000;
		err_count++;
		give_verdict();
	end
	initial begin
		nrst = 0;
		{cyc, stb, we, adr, sel, datI} = '0;
		repeat (3) @(posedge clk);
		nrst <= 1;
		for (int i = 0; i < 3; i++) begin
			wb(0, 4'(i * 4), 0, 4'h3);
			chk("reset", 0, rd);
		end
		for (int i = 0; i < 16; i++) begin
			v = (i < 8) ? {3'(i), 5'(i * 3), 3'(7 - i), 5'(31 - i * 3)} : 16'($random(seed));
			v = legalSel(v);
			wb(1, 4'h0, {16'h0000, v}, 4'h3);
			wb(0, 4'h0, 0, 4'h3);
			chk("sample", {16'h0000, v}, rd);
			chk("mux", 32'({negExp(v[15:13]), posExp(v[12:8]), negExp(v[7:5]),
				posExp(v[4:0])}), 32'(muxSel));
		end
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 16'hffff : 16'($random(seed));
			wb(1, 4'h8, {16'h0000, v}, 4'h3);
			wb(0, 4'h8, 0, 4'h3);
			chk("scanHigh", {16'h0000, v & 16'h7c03}, rd);
			chk("scanHighOut", 32'(v & 16'h7c03), 32'(scanHigh));
			wb(1, 4'h4, {16'h0000, ~v}, 4'h3);
			wb(0, 4'h4, 0, 4'h3);
			chk("scanLow", {16'h0000, ~v}, rd);
			chk("scanLowOut", {16'h0000, ~v}, 32'(scanLow));
			chk("scanCount", 32'($countones({v & 16'h7c03, ~v})), 32'(scanCount));
		end
		wb(1, 4'h0, 32'h0000_0721, 4'h3);
		wb(1, 4'h0, 32'h0000_2cff, 4'h2);
		wb(1, 4'hc, 32'h0000_0000, 4'h3);
		chk("unmapped", 1, 32'(er));
		wb(1, 4'h0, 32'h0000_ffa5, 4'h1);
		wb(0, 4'h0, 0, 4'h3);
		chk("lane", 32'h0000_2ca5, rd);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
